// File: uesd_cfg.svh
`ifndef UESD_CFG_SVH
`define UESD_CFG_SVH

// Register offsets
`define UESD_OFF_SEL0     12'h000
`define UESD_OFF_CNT0     12'h004
`define UESD_CTR_STRIDE   12'h008
`define UESD_OFF_CTRL     12'h020
`define UESD_OFF_STATUS   12'h024
`define UESD_NUM_CTR      4

// Field positions
`define UESD_SEL_EVT_LSB  0
`define UESD_SEL_UM_LSB   8
`define UESD_SEL_EN_BIT   22
`define UESD_SEL_MASK     32'h0040FFFF
`define UESD_CTRL_EN_BIT  0
`define UESD_CTRL_CLR_BIT 1
`define UESD_CTRL_MASK    32'h00000001

// Reset values
`define UESD_SEL_RST      32'h00000000
`define UESD_CTRL_RST     32'h00000000
`define UESD_CNT_RST      32'h00000000

// Event numbers
`define UESD_EVT_PARTIAL  8'h2F
`define UESD_EVT_CANCEL   8'h30
`define UESD_EVT_PRIO     8'h31
`define UESD_EVT_FRC_ACK  8'h33
`define UESD_EVT_SF_STALL 8'h40
`define UESD_EVT_MF_STALL 8'h41

// Unit mask values
`define UESD_UM_B0        8'h01
`define UESD_UM_B1        8'h02
`define UESD_UM_B2        8'h04
`define UESD_UM_B3        8'h08
`define UESD_UM_B4        8'h10
`define UESD_UM_B5        8'h20
`define UESD_UM_LOW       8'h07
`define UESD_UM_HIGH      8'h38
`define UESD_NUM_CHAN     2'h3

`endif

// File: uesd_pkg.sv
`default_nettype none
package uesd_pkg;
    // Bus slave states
    typedef enum logic [2:0] {
        UESD_ST_IDLE = 3'b001,
        UESD_ST_ACC  = 3'b010,
        UESD_ST_DONE = 3'b100
    } uesd_apb_e;
    // Six sub-conditions, one per mask bit
    typedef logic [5:0] uesd_cond_t;
    // Increment per cycle
    typedef logic [2:0] uesd_inc_t;
endpackage : uesd_pkg
`default_nettype wire

// File: uesd_evt_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "uesd_cfg.svh"
module uesd_evt_decode (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Selection
    input  wire logic [7:0]           evt,
    input  wire logic [7:0]           umask,
    input  wire logic                 enable,
    // Event sources
    input  wire logic [2:0]           partial,
    input  wire logic [2:0]           cancel,
    input  wire logic [2:0]           prio,
    input  wire logic                 frc_ack,
    input  wire logic [5:0]           sf_stall,
    input  wire logic [5:0]           mf_stall,
    // Increment
    output uesd_pkg::uesd_inc_t       inc
);
    // Conditions behind each mask bit for an event number
    function automatic uesd_pkg::uesd_cond_t cond_sel(input logic [7:0] e,
        input logic [2:0] pw, input logic [2:0] cw, input logic [2:0] pu,
        input logic fa, input logic [5:0] ss, input logic [5:0] ms);
        case (e)
            `UESD_EVT_PARTIAL:  cond_sel = {pw, 3'h0};
            `UESD_EVT_CANCEL:   cond_sel = {3'h0, cw};
            `UESD_EVT_PRIO:     cond_sel = {3'h0, pu};
            `UESD_EVT_FRC_ACK:  cond_sel = {3'h0, fa, 2'h0};
            `UESD_EVT_SF_STALL: cond_sel = ss;
            `UESD_EVT_MF_STALL: cond_sel = ms;
            default:            cond_sel = 6'h00;
        endcase
    endfunction : cond_sel

    // Number of set bits
    function automatic uesd_pkg::uesd_inc_t popcnt6(input logic [5:0] v);
        popcnt6 = 3'h0;
        for (int i = 0; i < 6; i++) begin
            popcnt6 = popcnt6 + {2'h0, v[i]};
        end
    endfunction : popcnt6

    // Mask gating and per-cycle increment
    wire uesd_pkg::uesd_cond_t cond     = cond_sel(evt, partial, cancel, prio, frc_ack,
                                                   sf_stall, mf_stall);
    wire uesd_pkg::uesd_cond_t hits     = cond & umask[5:0];
    wire logic                 is_cycle = (evt == `UESD_EVT_SF_STALL) ||
                                          (evt == `UESD_EVT_MF_STALL);
    wire uesd_pkg::uesd_inc_t  next_inc = !enable ? 3'h0 :
                                          is_cycle ? {2'h0, |hits} : popcnt6(hits);

    // Registered increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) inc <= 3'h0;
        else          inc <= next_inc;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sel(logic [7:0] e, logic [7:0] m);
        enable && evt == e && umask == m;
    endsequence
    a_partial_ch2: assert property (s_sel(`UESD_EVT_PARTIAL, `UESD_UM_B5) |=> inc == {2'h0, $past(partial[2])}) else $error("partial ch2 count wrong");
    a_partial_any: assert property (s_sel(`UESD_EVT_PARTIAL, `UESD_UM_HIGH) |=> inc == popcnt6({$past(partial), 3'h0})) else $error("partial any count wrong");
    a_cancel_ch1: assert property (s_sel(`UESD_EVT_CANCEL, `UESD_UM_B1) |=> inc == {2'h0, $past(cancel[1])}) else $error("cancel ch1 count wrong");
    a_cancel_any: assert property (s_sel(`UESD_EVT_CANCEL, `UESD_UM_LOW) ##0 cancel != 3'h0 |=> inc != 3'h0) else $error("cancel any missed");
    a_prio_ch0: assert property (s_sel(`UESD_EVT_PRIO, `UESD_UM_B0) |=> inc == {2'h0, $past(prio[0])}) else $error("prio ch0 count wrong");
    a_frc_local: assert property (s_sel(`UESD_EVT_FRC_ACK, `UESD_UM_B2) |=> inc == {2'h0, $past(frc_ack)}) else $error("force ack count wrong");
    a_sf_snoop0: assert property (s_sel(`UESD_EVT_SF_STALL, `UESD_UM_B1) |=> inc == {2'h0, $past(sf_stall[1])}) else $error("link0 snoop stall wrong");
    a_sf_ndr1: assert property (s_sel(`UESD_EVT_SF_STALL, `UESD_UM_B5) |=> inc == {2'h0, $past(sf_stall[5])}) else $error("link1 ndr stall wrong");
    a_sf_link1: assert property (s_sel(`UESD_EVT_SF_STALL, `UESD_UM_HIGH) |=> inc == {2'h0, |$past(sf_stall[5:3])}) else $error("link1 stall wrong");
    a_mf_ncs0: assert property (s_sel(`UESD_EVT_MF_STALL, `UESD_UM_B2) |=> inc == {2'h0, $past(mf_stall[2])}) else $error("link0 ncs stall wrong");
    a_mf_drs1: assert property (s_sel(`UESD_EVT_MF_STALL, `UESD_UM_B3)
        |=> inc == {2'h0, $past(mf_stall[3])}) else $error("link1 drs stall wrong");
    a_mf_link0: assert property (s_sel(`UESD_EVT_MF_STALL, `UESD_UM_LOW)
        |=> inc == {2'h0, |$past(mf_stall[2:0])}) else $error("link0 stall wrong");
    a_cycle_once: assert property (is_cycle |=> inc <= 3'h1) else $error("cycle event above one");
endmodule : uesd_evt_decode
`default_nettype wire

// File: uesd_ctr.sv
`timescale 1ns/1ps
`default_nettype none
`include "uesd_cfg.svh"
module uesd_ctr (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Software access
    input  wire logic                 clr,
    input  wire logic                 wr,
    input  wire logic [31:0]          wdata,
    // Increment
    input  wire uesd_pkg::uesd_inc_t  inc,
    // Value
    output logic [31:0]               count
);
    // Software write wins over clear and increment
    wire logic [31:0] next_count = wr ? wdata :
                                   clr ? `UESD_CNT_RST : count + {29'h0, inc};

    // Counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) count <= `UESD_CNT_RST;
        else          count <= next_count;
    end

    a_ctr_step: assert property (@(posedge pclk) disable iff (!presetn)
        !wr && !clr |=> count == $past(count) + {29'h0, $past(inc)}) else $error("counter step wrong");
endmodule : uesd_ctr
`default_nettype wire

// File: uesd_top.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "uesd_cfg.svh"
module uesd_top (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Memory controller events, one bit per channel
    input  wire logic [2:0]           memctl_partial_line_writes,
    input  wire logic [2:0]           memctl_cancel_requests,
    // Home logic request tracking
    input  wire logic                 isochronous_request_valid,
    input  wire logic                 isochronous_request_urgent,
    input  wire logic [1:0]           isochronous_request_chan,
    input  wire logic                 normal_match_issued,
    input  wire logic                 home_force_ack_conflicts,
    // Outbound link channels, bit = link * 3 + channel
    input  wire logic [5:0]           sf_vc_pending,
    input  wire logic [5:0]           sf_dedicated_credit,
    input  wire logic [5:0]           mf_vc_pending,
    input  wire logic [5:0]           mf_dedicated_credit,
    input  wire logic [1:0]           shared_credit_pool,
    // Priority update to the memory controller
    output logic                      memctl_priority_updates,
    output logic [1:0]                memctl_priority_chan
);
    localparam int NC = `UESD_NUM_CTR;

    // Byte lane merge for writes
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            merge_strb[b*8 +: 8] = st[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge_strb

    // Bus state and registers
    uesd_pkg::uesd_apb_e  state;
    uesd_pkg::uesd_apb_e  next_state;
    logic [31:0]          sel [NC];
    logic [31:0]          ctrl;
    logic                 clr_all;
    logic [11:0]          status_snap;
    logic [31:0]          count [NC];
    uesd_pkg::uesd_inc_t  ctr_inc [NC];

    // Address decode
    wire logic        aligned   = (paddr[1:0] == 2'h0);
    wire logic        in_ctrs   = (paddr < `UESD_OFF_CTRL);
    wire logic [1:0]  ctr_idx   = paddr[4:3];
    wire logic        is_cnt    = paddr[2];
    wire logic        is_ctrl   = (paddr == `UESD_OFF_CTRL);
    wire logic        is_status = (paddr == `UESD_OFF_STATUS);
    wire logic        addr_hit  = aligned && (in_ctrs || is_ctrl || is_status);

    // Read selection, reserved bits zero
    wire logic [31:0] rd_ctr  = is_cnt ? count[ctr_idx] : (sel[ctr_idx] & `UESD_SEL_MASK);
    wire logic [31:0] rd_mux  = !addr_hit ? 32'h00000000 :
                                in_ctrs   ? rd_ctr :
                                is_ctrl   ? (ctrl & `UESD_CTRL_MASK) :
                                {20'h00000, status_snap};

    // Write commit at the completing edge only
    wire logic        acc_end   = (state == uesd_pkg::UESD_ST_DONE) && psel && penable;
    wire logic        wr_commit = acc_end && pwrite && addr_hit;
    wire logic [31:0] wr_ctrl   = merge_strb(ctrl, pwdata, pstrb);

    // Bus sequencing
    always_comb begin
        next_state = state;
        case (state)
            uesd_pkg::UESD_ST_IDLE: begin
                if (psel && !penable) next_state = uesd_pkg::UESD_ST_ACC;
            end
            uesd_pkg::UESD_ST_ACC: begin
                next_state = uesd_pkg::UESD_ST_DONE;
            end
            uesd_pkg::UESD_ST_DONE: begin
                next_state = uesd_pkg::UESD_ST_IDLE;
            end
            default: begin
                next_state = uesd_pkg::UESD_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state <= uesd_pkg::UESD_ST_IDLE;
        else          state <= next_state;
    end

    // One wait state, then ready with data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= (state == uesd_pkg::UESD_ST_ACC);
            pslverr <= (state == uesd_pkg::UESD_ST_ACC) && !addr_hit;
            if (state == uesd_pkg::UESD_ST_ACC && !pwrite) prdata <= rd_mux;
        end
    end

    // Selection registers
    for (genvar g = 0; g < NC; g++) begin : g_sel
        wire logic sel_wr = wr_commit && in_ctrs && !is_cnt &&
                            (ctr_idx == 2'(g));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)    sel[g] <= `UESD_SEL_RST;
            else if (sel_wr) sel[g] <= merge_strb(sel[g], pwdata, pstrb) & `UESD_SEL_MASK;
        end
    end

    // Global control; clear bit acts for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= `UESD_CTRL_RST;
            clr_all <= 1'b0;
        end else begin
            clr_all <= wr_commit && is_ctrl && wr_ctrl[`UESD_CTRL_CLR_BIT];
            if (wr_commit && is_ctrl) ctrl <= wr_ctrl & `UESD_CTRL_MASK;
        end
    end

    // Stall: pending with neither credit kind; arbitration grant not consulted
    wire logic [5:0] shared_ext = {{3{shared_credit_pool[1]}}, {3{shared_credit_pool[0]}}};
    wire logic [5:0] sf_stall   = sf_vc_pending & ~sf_dedicated_credit & ~shared_ext;
    wire logic [5:0] mf_stall   = mf_vc_pending & ~mf_dedicated_credit & ~shared_ext;

    // Live stall snapshot for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) status_snap <= 12'h000;
        else          status_snap <= {mf_stall, sf_stall};
    end

    // Priority update when an urgent isochronous request hits an issued normal one
    wire logic prio_hit = isochronous_request_valid && isochronous_request_urgent &&
                          normal_match_issued &&
                          (isochronous_request_chan != `UESD_NUM_CHAN);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memctl_priority_updates <= 1'b0;
            memctl_priority_chan    <= 2'h0;
        end else begin
            memctl_priority_updates <= prio_hit;
            if (prio_hit) memctl_priority_chan <= isochronous_request_chan;
        end
    end

    // Issued priority update per channel, counted as it leaves
    wire logic [2:0] prio_onehot = !memctl_priority_updates ? 3'h0 :
                                   (3'h1 << memctl_priority_chan);

    // Counter slices
    for (genvar g = 0; g < NC; g++) begin : g_ctr
        wire logic cnt_wr = wr_commit && in_ctrs && is_cnt && (ctr_idx == 2'(g));
        wire logic en     = sel[g][`UESD_SEL_EN_BIT] && ctrl[`UESD_CTRL_EN_BIT];

        uesd_evt_decode u_dec (
            .pclk     (pclk),
            .presetn  (presetn),
            .evt      (sel[g][`UESD_SEL_EVT_LSB +: 8]),
            .umask    (sel[g][`UESD_SEL_UM_LSB +: 8]),
            .enable   (en),
            .partial  (memctl_partial_line_writes),
            .cancel   (memctl_cancel_requests),
            .prio     (prio_onehot),
            .frc_ack  (home_force_ack_conflicts),
            .sf_stall (sf_stall),
            .mf_stall (mf_stall),
            .inc      (ctr_inc[g])
        );

        uesd_ctr u_ctr (
            .pclk     (pclk),
            .presetn  (presetn),
            .clr      (clr_all),
            .wr       (cnt_wr),
            .wdata    (merge_strb(count[g], pwdata, pstrb)),
            .inc      (ctr_inc[g]),
            .count    (count[g])
        );
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus phases
    sequence s_setup;
        psel && !penable && state == uesd_pkg::UESD_ST_IDLE;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence

    a_apb_wait: assert property (s_setup ##1 s_wait |=> pready) else $error("ready not after one wait");
    a_apb_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_apb_err: assert property (s_setup ##0 !addr_hit ##1 s_wait |=> pslverr) else $error("unmapped not refused");
    a_prio_issue: assert property (prio_hit |=> memctl_priority_updates && memctl_priority_chan == $past(isochronous_request_chan)) else $error("priority update missing");
    a_prio_quiet: assert property (!prio_hit |=> !memctl_priority_updates) else $error("spurious priority update");
    a_prio_count: assert property (memctl_priority_updates && sel[0][7:0] == `UESD_EVT_PRIO && sel[0][15:8] == `UESD_UM_LOW && sel[0][22] && ctrl[0] |=> ctr_inc[0] == 3'h1) else $error("priority update not counted");
    a_stall_count: assert property (sel[0][7:0] == `UESD_EVT_SF_STALL && sel[0][15:8] == `UESD_UM_B0 && sel[0][22] && ctrl[0] && sf_vc_pending[0] && !sf_dedicated_credit[0] && !shared_credit_pool[0] |=> ctr_inc[0] == 3'h1) else $error("credit stall not counted");
    a_credit_blocks: assert property (sf_dedicated_credit[3] || shared_credit_pool[1] |-> !sf_stall[3]) else $error("stall with credit");
endmodule : uesd_top
`default_nettype wire

// File: uesd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uesd_cfg.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module uesd_top_tb_top;
    // Clock, reset and bus
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, memctl_priority_updates;
    logic [1:0]  memctl_priority_chan, isochronous_request_chan = 0, shared_credit_pool = 0;
    // Event sources
    logic [2:0]  memctl_partial_line_writes = 0, memctl_cancel_requests = 0;
    logic        isochronous_request_valid = 0, isochronous_request_urgent = 0;
    logic        normal_match_issued = 0, home_force_ack_conflicts = 0;
    logic [5:0]  sf_vc_pending = 0, sf_dedicated_credit = 0;
    logic [5:0]  mf_vc_pending = 0, mf_dedicated_credit = 0;
    // Scoreboard state
    int          errors = 0, compares = 0, seed = 27671;
    logic [33:0] notes[$];
    logic [33:0] nt;
    logic        ph_q = 0;
    logic [1:0]  pc_q = 0;
    logic [31:0] ex;
    // Event and mask pairs swept one by one
    localparam logic [15:0] TBL [0:28] = '{16'h2F20, 16'h2F38,
        16'h3001, 16'h3002, 16'h3004, 16'h3007,
        16'h3101, 16'h3102, 16'h3104, 16'h3107,
        16'h3304, 16'h3303,
        16'h4001, 16'h4002, 16'h4004, 16'h4008, 16'h4010, 16'h4020,
        16'h4007, 16'h4038,
        16'h4101, 16'h4102, 16'h4104, 16'h4108, 16'h4110, 16'h4120, 16'h4107,
        16'h4138, 16'h55FF};

    uesd_top u_uesd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .memctl_partial_line_writes, .memctl_cancel_requests,
        .isochronous_request_valid, .isochronous_request_urgent, .isochronous_request_chan,
        .normal_match_issued, .home_force_ack_conflicts, .sf_vc_pending, .sf_dedicated_credit,
        .mf_vc_pending, .mf_dedicated_credit, .shared_credit_pool, .memctl_priority_updates,
        .memctl_priority_chan);

    // Clock
    always #5 pclk = ~pclk;

    // Stall seen by a channel: pending with no credit of either kind
    function automatic logic [5:0] stl(input logic [5:0] p, d, input logic [1:0] s);
        return p & ~d & ~{{3{s[1]}}, {3{s[0]}}};
    endfunction : stl

    // Expected increment for one cycle of sources
    function automatic logic [2:0] exp_inc(input logic [7:0] ev, um, input logic [2:0] pw, cw,
            pu, input logic fa, input logic [5:0] ss, ms);
        case (ev)
            8'h2F: return 3'($countones(um[5:3] & pw));
            8'h30: return 3'($countones(um[2:0] & cw));
            8'h31: return 3'($countones(um[2:0] & pu));
            8'h33: return {2'h0, um[2] & fa};
            8'h40: return {2'h0, |(um[5:0] & ss)};
            8'h41: return {2'h0, |(um[5:0] & ms)};
            default: return 3'h0;
        endcase
    endfunction : exp_inc

    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // One APB transfer; the expected answer is queued for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, ed,
            input logic ee);
        notes.push_back({ee, ~w, ed});
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask : apb

    // Drive all event sources from two random words
    task automatic drive(input logic [31:0] r1, r2);
        memctl_partial_line_writes <= r1[2:0]; memctl_cancel_requests <= r1[5:3];
        isochronous_request_valid <= r1[6]; isochronous_request_urgent <= r1[7];
        isochronous_request_chan <= r1[9:8]; normal_match_issued <= r1[10];
        home_force_ack_conflicts <= r1[11]; sf_vc_pending <= r1[17:12];
        sf_dedicated_credit <= r1[23:18]; mf_vc_pending <= r1[29:24];
        shared_credit_pool <= r2[1:0]; mf_dedicated_credit <= r2[7:2];
    endtask : drive

    // Random traffic for twenty cycles, then quiet until all is counted
    task automatic burst(input logic [7:0] ev, um, inout logic [31:0] e);
        logic [31:0] r1, r2;
        logic [2:0]  pu;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            r1 = $random(seed);
            r2 = $random(seed);
            drive(r1, r2);
            pu = (r1[6] & r1[7] & r1[10] & (r1[9:8] != 2'h3)) ? 3'h1 << r1[9:8] : 3'h0;
            e += exp_inc(ev, um, r1[2:0], r1[5:3], pu, r1[11], stl(r1[17:12], r1[23:18],
                r2[1:0]), stl(r1[29:24], r2[7:2], r2[1:0]));
        end
        @(posedge pclk);
        drive(0, 0);
        repeat (5) @(posedge pclk);
    endtask : burst

    // Monitor: each completed transfer against the oldest note
    always @(posedge pclk) if (psel === 1 && penable === 1 && pready === 1) begin
        if (notes.size() == 0) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, 1'b1, 1'b0);
        end else begin
            nt = notes.pop_front();
            `CHK(pslverr, nt[33])
            if (nt[32]) `CHK(prdata, nt[31:0])
        end
    end

    // Priority update one cycle after an urgent isochronous hit
    always @(posedge pclk) if (presetn === 1'b1) begin
        `CHK(memctl_priority_updates, ph_q)
        if (ph_q) `CHK(memctl_priority_chan, pc_q)
        ph_q = isochronous_request_valid & isochronous_request_urgent & normal_match_issued
            & (isochronous_request_chan != 2'h3);
        pc_q = isochronous_request_chan;
    end

    // Watchdog
    initial begin
        #200000;
        errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        logic [31:0] q1, q2;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, `UESD_OFF_SEL0, 0, `UESD_SEL_RST, 0);
        apb(0, `UESD_OFF_CTRL, 0, `UESD_CTRL_RST, 0);
        apb(0, `UESD_OFF_CNT0, 0, `UESD_CNT_RST, 0);
        apb(0, 12'h030, 0, 0, 1);
        apb(0, 12'h002, 0, 0, 1);
        apb(1, `UESD_OFF_SEL0 + `UESD_CTR_STRIDE, 32'hFFFFFFFF, 0, 0);
        apb(0, `UESD_OFF_SEL0 + `UESD_CTR_STRIDE, 0, `UESD_SEL_MASK, 0);
        apb(1, `UESD_OFF_CTRL, 1, 0, 0);
        foreach (TBL[k]) begin
            apb(1, `UESD_OFF_SEL0, {9'h0, 1'b1, 6'h0, TBL[k][7:0], TBL[k][15:8]}, 0, 0);
            apb(1, `UESD_OFF_CNT0, 0, 0, 0);
            ex = 0;
            burst(TBL[k][15:8], TBL[k][7:0], ex);
            apb(0, `UESD_OFF_CNT0, 0, ex, 0);
        end
        // Status snapshot of the live stall vectors
        q1 = $random(seed);
        q2 = $random(seed);
        @(posedge pclk);
        drive(q1, q2);
        apb(0, `UESD_OFF_STATUS, 0, {20'h0, stl(q1[29:24], q2[7:2], q2[1:0]),
            stl(q1[17:12], q1[23:18], q2[1:0])}, 0);
        drive(0, 0);
        // Byte lanes merge into a counter, then the global clear empties it
        apb(1, `UESD_OFF_CNT0, 32'h0000ABCD, 0, 0);
        pstrb <= 4'h2;
        apb(1, `UESD_OFF_CNT0, 32'h12345678, 0, 0);
        pstrb <= 4'hF;
        apb(0, `UESD_OFF_CNT0, 0, 32'h000056CD, 0);
        apb(1, `UESD_OFF_CTRL, 3, 0, 0);
        apb(0, `UESD_OFF_CNT0, 0, `UESD_CNT_RST, 0);
        apb(0, `UESD_OFF_CTRL, 0, 32'h00000001, 0);
        repeat (3) @(posedge pclk);
        wrap_up();
    end
endmodule : uesd_top_tb_top
`default_nettype wire
